/* src/msa_consts.vh */
`ifndef MSA_CONSTS_VH
`define MSA_CONSTS_VH

// ----------------------------------------------------------------
// internal clock and conversion timing, in internal clock periods
// ----------------------------------------------------------------
`define MSA_OSC_DIV        4
`define MSA_CYCLE_TICKS    1280
`define MSA_ZERO_TICKS     246
`define MSA_INTEG_TICKS    256
`define MSA_DEINT_TICKS    778
`define MSA_FAST_MAX       512
`define MSA_SLOW_MAX       64
`define MSA_OVR_MAX        64
`define MSA_OVR_PHASES     3
`define MSA_SETTLE_TICKS   10
`define MSA_BUSY_TICKS     836

// ----------------------------------------------------------------
// result layout
// ----------------------------------------------------------------
`define MSA_FAST_BITS      9
`define MSA_SLOW_BITS      6
`define MSA_RESULT_BITS    15

`endif

/* src/msa_clk_div.v */
`timescale 1ns/10ps

// ----------------------------------------------------------------
// oscillator divider: one-cycle tick every DIV input clocks
// ----------------------------------------------------------------
module msa_clk_div #(
    parameter DIV = 4
) (
    input  wire clk,
    input  wire nrst,
    output reg  tick
);

    reg  [7:0] cnt_reg;

    always @(posedge clk) begin
        if (!nrst) begin
            cnt_reg <= 8'h00;
            tick    <= 1'b0;
        end else if (cnt_reg == DIV - 1) begin
            cnt_reg <= 8'h00;
            tick    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            tick    <= 1'b0;
        end
    end

endmodule // msa_clk_div

/* src/msa_read_port.v */
`timescale 1ns/10ps
`include "msa_consts.vh"

// ----------------------------------------------------------------
// byte read port for the latched result (demand-mode layout)
// ----------------------------------------------------------------
module msa_read_port (
    input  wire                          clk,
    input  wire                          nrst,
    input  wire                          chip_en,
    input  wire                          rd_n,
    input  wire                          low_sel,
    input  wire                          ovr_sel,
    input  wire [`MSA_RESULT_BITS-1:0]   result,
    input  wire                          polarity,
    input  wire                          overrange,
    output reg  [7:0]                    db_out,
    output wire                          db_oe
);

    reg  [7:0] byte_next;

    assign db_oe = chip_en & ~rd_n;

    always @* begin
        if (low_sel) begin
            byte_next = result[7:0];
        end else begin
            byte_next = {(ovr_sel ? overrange : polarity), result[14:8]};
        end
    end

    // data registered so the bus sees a clean byte one clock after select
    always @(posedge clk) begin
        if (!nrst) begin
            db_out <= 8'h00;
        end else begin
            db_out <= byte_next;
        end
    end

endmodule // msa_read_port

/* src/msa_sequencer.v */
`timescale 1ns/10ps
`include "msa_consts.vh"

module msa_sequencer #(
    parameter ZERO_TICKS  = `MSA_ZERO_TICKS,
    parameter INTEG_TICKS = `MSA_INTEG_TICKS,
    parameter DEINT_TICKS = `MSA_DEINT_TICKS,
    parameter BUSY_TICKS  = `MSA_BUSY_TICKS
) (
    input  wire                          REF_CLK,
    input  wire                          NRST,
    input  wire                          MODE_SELECT_INPUT,
    input  wire                          CHIP_ENABLE_N,
    input  wire                          CHIP_SELECT,
    input  wire                          CONVERT_N,
    input  wire                          READ_N,
    input  wire                          LOW_HIGH_SEL,
    input  wire                          OVR_POL_SEL,
    input  wire                          COMP_IN,
    output reg                           BUSY,
    output reg                           DATA_VALID,
    output reg  [`MSA_RESULT_BITS-1:0]   RESULT,
    output reg                           POLARITY,
    output reg                           OVERRANGE,
    output wire [7:0]                    DB_OUT,
    output wire                          DB_OE,
    output reg                           SW_ZERO_LOOP,
    output reg                           SW_COMMON_SHORT,
    output reg                           SW_INPUT_CONNECT,
    output reg                           SW_NEG_TO_COMMON,
    output reg                           SW_PRIMARY_REF_CAP,
    output reg                           SW_FINE_REF_CAP
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam ST_IDLE   = 3'h0;
    localparam ST_ZERO   = 3'h1;
    localparam ST_INTEG  = 3'h2;
    localparam ST_FAST   = 3'h3;
    localparam ST_SLOW   = 3'h4;
    localparam ST_OVR    = 3'h5;
    localparam ST_SETTLE = 3'h6;

    localparam [9:0] ZERO_LAST  = ZERO_TICKS - 1;
    localparam [9:0] INTEG_LAST = INTEG_TICKS - 1;
    localparam [9:0] DEINT_LAST = DEINT_TICKS - 1;
    localparam [9:0] BUSY_LAST  = BUSY_TICKS - 1;
    localparam [9:0] FAST_LAST  = `MSA_FAST_MAX - 1;
    localparam [9:0] SLOW_LAST  = `MSA_SLOW_MAX - 1;
    localparam [9:0] OVR_LAST   = `MSA_OVR_MAX - 1;
    localparam [1:0] OVR_FINAL  = `MSA_OVR_PHASES - 1;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    wire       tick;
    wire       chip_en;
    wire       wr_qual;
    wire       wr_start;
    wire       crossing;
    wire       busy_end;
    wire [`MSA_RESULT_BITS-1:0] result_work;

    reg  [2:0] state_reg,   state_next;
    reg  [9:0] phase_reg,   phase_next;
    reg  [9:0] deint_reg,   deint_next;
    reg  [9:0] busy_cnt_reg;
    reg  [8:0] fast_reg,    fast_next;
    reg  [5:0] slow_reg,    slow_next;
    reg  [7:0] ovr_cnt_reg, ovr_cnt_next;
    reg  [1:0] ovr_idx_reg, ovr_idx_next;
    reg        fast_full_reg, fast_full_next;
    reg        ovr_flag_reg,  ovr_flag_next;
    reg        pol_reg,       pol_next;
    reg        entry_reg,     entry_next;
    reg        busy_start;
    reg        wr_qual_d_reg;
    reg        pending_reg;
    reg        consume;

    // ----------------------------------------------------------------
    // internal clock
    // ----------------------------------------------------------------
    // divide by four
    msa_clk_div #(
        .DIV  (`MSA_OSC_DIV)
    ) u_div (
        .clk  (REF_CLK),
        .nrst (NRST),
        .tick (tick)
    );

    // ----------------------------------------------------------------
    // convert strobe
    // ----------------------------------------------------------------
    // qualify strobes
    assign chip_en  = ~CHIP_ENABLE_N & CHIP_SELECT;
    assign wr_qual  = chip_en & ~CONVERT_N & ~MODE_SELECT_INPUT;
    assign wr_start = wr_qual & ~wr_qual_d_reg;

    assign crossing = COMP_IN != entry_reg;

    assign result_work = ovr_flag_reg ? {7'h00, ovr_cnt_reg} : {fast_reg, slow_reg};

    assign busy_end = BUSY & tick & (busy_cnt_reg == BUSY_LAST);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always @* begin
        state_next     = state_reg;
        phase_next     = phase_reg;
        deint_next     = deint_reg;
        fast_next      = fast_reg;
        slow_next      = slow_reg;
        ovr_cnt_next   = ovr_cnt_reg;
        ovr_idx_next   = ovr_idx_reg;
        fast_full_next = fast_full_reg;
        ovr_flag_next  = ovr_flag_reg;
        pol_next       = pol_reg;
        entry_next     = entry_reg;
        busy_start     = 1'b0;
        consume        = 1'b0;
        if (tick) begin
            phase_next = phase_reg + 10'h001;
            case (state_reg)
                ST_IDLE: begin
                    phase_next = 10'h000;
                    if (MODE_SELECT_INPUT || pending_reg) begin
                        consume    = ~MODE_SELECT_INPUT;
                        state_next = ST_ZERO;
                    end
                end
                ST_ZERO: begin
                    if (phase_reg == ZERO_LAST) begin
                        state_next = ST_INTEG;
                        phase_next = 10'h000;
                    end
                end
                ST_INTEG: begin
                    if (phase_reg == INTEG_LAST) begin
                        state_next     = ST_FAST;
                        phase_next     = 10'h000;
                        deint_next     = 10'h000;
                        pol_next       = COMP_IN;
                        entry_next     = COMP_IN;
                        fast_next      = 9'h000;
                        slow_next      = 6'h00;
                        ovr_cnt_next   = 8'h00;
                        ovr_idx_next   = 2'h0;
                        fast_full_next = 1'b0;
                        ovr_flag_next  = 1'b0;
                        busy_start     = 1'b1;
                    end
                end
                ST_FAST: begin
                    deint_next = deint_reg + 10'h001;
                    if (crossing || phase_reg == FAST_LAST) begin
                        fast_next      = phase_reg[8:0];
                        fast_full_next = ~crossing;
                        state_next     = ST_SLOW;
                        phase_next     = 10'h000;
                        entry_next     = COMP_IN;
                    end
                end
                ST_SLOW: begin
                    deint_next = deint_reg + 10'h001;
                    if (crossing || phase_reg == SLOW_LAST) begin
                        slow_next  = phase_reg[5:0];
                        phase_next = 10'h000;
                        entry_next = COMP_IN;
                        if (!crossing && fast_full_reg) begin
                            state_next = ST_OVR;
                        end else begin
                            state_next = ST_SETTLE;
                        end
                    end
                end
                ST_OVR: begin
                    deint_next = deint_reg + 10'h001;
                    if (crossing || (phase_reg == OVR_LAST && ovr_idx_reg == OVR_FINAL)) begin
                        ovr_cnt_next  = {ovr_idx_reg, phase_reg[5:0]};
                        ovr_flag_next = 1'b1;
                        state_next    = ST_SETTLE;
                    end else if (phase_reg == OVR_LAST) begin
                        ovr_idx_next = ovr_idx_reg + 2'h1;
                        phase_next   = 10'h000;
                        entry_next   = COMP_IN;
                    end
                end
                ST_SETTLE: begin
                    deint_next = deint_reg + 10'h001;
                    if (deint_reg == DEINT_LAST) begin
                        phase_next = 10'h000;
                        state_next = MODE_SELECT_INPUT ? ST_ZERO : ST_IDLE;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    phase_next = 10'h000;
                end
            endcase
        end
    end

    always @(posedge REF_CLK) begin
        if (!NRST) begin
            state_reg     <= ST_IDLE;
            phase_reg     <= 10'h000;
            deint_reg     <= 10'h000;
            fast_reg      <= 9'h000;
            slow_reg      <= 6'h00;
            ovr_cnt_reg   <= 8'h00;
            ovr_idx_reg   <= 2'h0;
            fast_full_reg <= 1'b0;
            ovr_flag_reg  <= 1'b0;
            pol_reg       <= 1'b0;
            entry_reg     <= 1'b0;
            wr_qual_d_reg <= 1'b0;
            pending_reg   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            phase_reg     <= phase_next;
            deint_reg     <= deint_next;
            fast_reg      <= fast_next;
            slow_reg      <= slow_next;
            ovr_cnt_reg   <= ovr_cnt_next;
            ovr_idx_reg   <= ovr_idx_next;
            fast_full_reg <= fast_full_next;
            ovr_flag_reg  <= ovr_flag_next;
            pol_reg       <= pol_next;
            entry_reg     <= entry_next;
            wr_qual_d_reg <= wr_qual;
            // a strobe arriving in the consuming cycle is kept
            if (wr_start) begin
                pending_reg <= 1'b1;
            end else if (consume) begin
                pending_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // busy and result latch
    // ----------------------------------------------------------------
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            BUSY         <= 1'b0;
            busy_cnt_reg <= 10'h000;
            DATA_VALID   <= 1'b0;
            RESULT       <= 15'h0000;
            POLARITY     <= 1'b0;
            OVERRANGE    <= 1'b0;
        end else begin
            if (busy_start) begin
                BUSY         <= 1'b1;
                busy_cnt_reg <= 10'h000;
            end else if (busy_end) begin
                BUSY <= 1'b0;
            end else if (BUSY && tick) begin
                busy_cnt_reg <= busy_cnt_reg + 10'h001;
            end
            if (busy_end) begin
                RESULT     <= result_work;
                POLARITY   <= pol_reg;
                OVERRANGE  <= ovr_flag_reg;
                DATA_VALID <= 1'b1;
            end else if (wr_start) begin
                DATA_VALID <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // analog switch controls, registered from the next state
    // ----------------------------------------------------------------
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            SW_ZERO_LOOP       <= 1'b1;
            SW_COMMON_SHORT    <= 1'b1;
            SW_INPUT_CONNECT   <= 1'b0;
            SW_NEG_TO_COMMON   <= 1'b1;
            SW_PRIMARY_REF_CAP <= 1'b0;
            SW_FINE_REF_CAP    <= 1'b0;
        end else begin
            SW_ZERO_LOOP       <= (state_next == ST_ZERO) || (state_next == ST_IDLE);
            SW_COMMON_SHORT    <= (state_next == ST_ZERO) || (state_next == ST_IDLE);
            SW_INPUT_CONNECT   <= (state_next == ST_INTEG);
            SW_NEG_TO_COMMON   <= (state_next != ST_INTEG);
            SW_PRIMARY_REF_CAP <= (state_next == ST_FAST);
            SW_FINE_REF_CAP    <= (state_next == ST_SLOW) || (state_next == ST_OVR);
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // read qualified too
    msa_read_port u_rd (
        .clk       (REF_CLK),
        .nrst      (NRST),
        .chip_en   (chip_en),
        .rd_n      (READ_N),
        .low_sel   (LOW_HIGH_SEL),
        .ovr_sel   (OVR_POL_SEL),
        .result    (RESULT),
        .polarity  (POLARITY),
        .overrange (OVERRANGE),
        .db_out    (DB_OUT),
        .db_oe     (DB_OE)
    );

endmodule // msa_sequencer

/* verif/msa_sequencer_props.sv */
`timescale 1ns/10ps
`include "msa_consts.vh"

module msa_seq_props #(
    parameter ZERO_TICKS  = `MSA_ZERO_TICKS,
    parameter INTEG_TICKS = `MSA_INTEG_TICKS,
    parameter DEINT_TICKS = `MSA_DEINT_TICKS,
    parameter BUSY_TICKS  = `MSA_BUSY_TICKS
) (
    input wire                        REF_CLK,
    input wire                        NRST,
    input wire                        MODE_SELECT_INPUT,
    input wire                        CHIP_ENABLE_N,
    input wire                        CHIP_SELECT,
    input wire                        READ_N,
    input wire                        BUSY,
    input wire                        DATA_VALID,
    input wire [`MSA_RESULT_BITS-1:0] RESULT,
    input wire                        DB_OE,
    input wire                        SW_ZERO_LOOP,
    input wire                        SW_COMMON_SHORT,
    input wire                        SW_INPUT_CONNECT,
    input wire                        SW_NEG_TO_COMMON,
    input wire                        SW_PRIMARY_REF_CAP,
    input wire                        SW_FINE_REF_CAP
);
    // ------------------------------------------------
    // phase length counters, in REF_CLK cycles
    // ------------------------------------------------
    logic [15:0] busy_cnt;
    logic [15:0] integ_cnt;
    logic [15:0] zero_cnt;
    logic [15:0] fast_cnt;
    logic [15:0] fine_cnt;
    logic        zero_after_deint;

    always @(posedge REF_CLK) begin
        if (!NRST) begin
            busy_cnt         <= 16'h0000;
            integ_cnt        <= 16'h0000;
            zero_cnt         <= 16'h0000;
            fast_cnt         <= 16'h0000;
            fine_cnt         <= 16'h0000;
            zero_after_deint <= 1'b0;
        end else begin
            busy_cnt  <= BUSY ? busy_cnt + 16'h0001 : 16'h0000;
            integ_cnt <= SW_INPUT_CONNECT ? integ_cnt + 16'h0001 : 16'h0000;
            zero_cnt  <= SW_ZERO_LOOP ? zero_cnt + 16'h0001 : 16'h0000;
            fast_cnt  <= SW_PRIMARY_REF_CAP ? fast_cnt + 16'h0001 : 16'h0000;
            fine_cnt  <= SW_FINE_REF_CAP ? fine_cnt + 16'h0001 : 16'h0000;
            // idle time in demand mode stretches zeroing, so only this case is timed
            if ($rose(SW_ZERO_LOOP)) begin
                zero_after_deint <= BUSY & MODE_SELECT_INPUT;
            end
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    a_busy_width: assert property ($fell(BUSY) |-> busy_cnt == 4 * BUSY_TICKS)
        else $error("busy high time wrong");
    a_deint_length: assert property ($rose(SW_ZERO_LOOP) |-> BUSY && busy_cnt == 4 * DEINT_TICKS)
        else $error("de-integration length wrong");
    a_zero_length: assert property ($fell(SW_ZERO_LOOP) && zero_after_deint |-> zero_cnt == 4 * ZERO_TICKS)
        else $error("zeroing length wrong");
    a_integ_length: assert property ($fell(SW_INPUT_CONNECT) |-> integ_cnt == 4 * INTEG_TICKS)
        else $error("integration length wrong");
    a_integ_entry: assert property ($rose(SW_INPUT_CONNECT) |-> $fell(SW_ZERO_LOOP) && !SW_COMMON_SHORT && !SW_NEG_TO_COMMON)
        else $error("integration entry switches wrong");
    a_zero_switches: assert property (SW_ZERO_LOOP |-> SW_COMMON_SHORT && SW_NEG_TO_COMMON && !SW_INPUT_CONNECT)
        else $error("zeroing switches wrong");
    a_common_return: assert property (!SW_INPUT_CONNECT |-> SW_NEG_TO_COMMON)
        else $error("negative input not on common");
    a_fast_entry: assert property ($fell(SW_INPUT_CONNECT) |-> $rose(BUSY) && SW_PRIMARY_REF_CAP && !SW_FINE_REF_CAP)
        else $error("fast phase entry wrong");
    a_fast_to_slow: assert property ($fell(SW_PRIMARY_REF_CAP) |-> SW_FINE_REF_CAP && fast_cnt <= 4 * `MSA_FAST_MAX)
        else $error("fast phase too long or not followed by slow");
    a_fine_limit: assert property ($fell(SW_FINE_REF_CAP) |-> fine_cnt >= 4 && fine_cnt <= 4 * (`MSA_SLOW_MAX + `MSA_OVR_PHASES * `MSA_OVR_MAX))
        else $error("slow and overrange time out of bounds");
    a_valid_at_fall: assert property ($fell(BUSY) |-> DATA_VALID)
        else $error("data not valid at busy fall");
    a_result_hold: assert property ($changed(RESULT) |-> $fell(BUSY))
        else $error("result changed away from busy fall");
    a_read_qualify: assert property (DB_OE == (!CHIP_ENABLE_N && CHIP_SELECT && !READ_N))
        else $error("bus enable not qualified");
endmodule // msa_seq_props

bind msa_sequencer msa_seq_props #(
    .ZERO_TICKS (ZERO_TICKS),
    .INTEG_TICKS(INTEG_TICKS),
    .DEINT_TICKS(DEINT_TICKS),
    .BUSY_TICKS (BUSY_TICKS)
) props_u (
    .REF_CLK, .NRST, .MODE_SELECT_INPUT, .CHIP_ENABLE_N, .CHIP_SELECT, .READ_N, .BUSY,
    .DATA_VALID, .RESULT, .DB_OE, .SW_ZERO_LOOP, .SW_COMMON_SHORT, .SW_INPUT_CONNECT,
    .SW_NEG_TO_COMMON, .SW_PRIMARY_REF_CAP, .SW_FINE_REF_CAP
);

/* verif/msa_host_model.sv */
`timescale 1ns/10ps

module msa_host_model (
    input  wire        clk,
    input  wire        busy,
    input  wire  [7:0] db,
    input  wire        db_oe,
    output logic       ce_n,
    output logic       cs,
    output logic       cvt_n,
    output logic       rd_n,
    output logic       lo_sel,
    output logic       ovr_sel
);
    initial begin
        ce_n = 1'b1;
        cs = 1'b0;
        cvt_n = 1'b1;
        rd_n = 1'b1;
        lo_sel = 1'b0;
        ovr_sel = 1'b0;
    end

    task automatic start(input logic qual);
        @(posedge clk);
        #1;
        ce_n = 1'b0;
        cs = qual;
        cvt_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        cvt_n = 1'b1;
        ce_n = 1'b1;
        cs = 1'b0;
    endtask

    // byte read once busy is low
    task automatic read_byte(input logic en, input logic lo, input logic ovr,
                             output logic [7:0] b, output logic oe);
        while (busy !== 1'b0) @(posedge clk);
        @(posedge clk);
        #1;
        ce_n = !en;
        cs = 1'b1;
        lo_sel = lo;
        ovr_sel = ovr;
        rd_n = 1'b0;
        repeat (2) @(posedge clk);
        // sample after the edge has settled, never in the launching time step
        #1;
        b = db;
        oe = db_oe;
        ce_n = 1'b1;
        cs = 1'b0;
        rd_n = 1'b1;
        // released selects do not keep their last level
        lo_sel = !lo;
        ovr_sel = !ovr;
    endtask
endmodule // msa_host_model

/* verif/msa_sequencer_test.sv */
`timescale 1ns/10ps

module msa_sequencer_test;
    logic        REF_CLK = 1'b0;
    logic        NRST = 1'b0;
    logic        MODE_SELECT_INPUT = 1'b0;
    logic        COMP_IN = 1'b0;
    wire         CHIP_ENABLE_N, CHIP_SELECT, CONVERT_N, READ_N, LOW_HIGH_SEL, OVR_POL_SEL;
    wire         BUSY, DATA_VALID, POLARITY, OVERRANGE, DB_OE;
    wire  [14:0] RESULT;
    wire  [7:0]  DB_OUT;
    wire         SW_ZERO_LOOP, SW_COMMON_SHORT, SW_INPUT_CONNECT;
    wire         SW_NEG_TO_COMMON, SW_PRIMARY_REF_CAP, SW_FINE_REF_CAP;
    integer      bad_count = 0;
    integer      total_checks = 0;

    always #5 REF_CLK = ~REF_CLK;

    msa_sequencer dut_u (
        .REF_CLK, .NRST, .MODE_SELECT_INPUT, .CHIP_ENABLE_N, .CHIP_SELECT, .CONVERT_N,
        .READ_N, .LOW_HIGH_SEL, .OVR_POL_SEL, .COMP_IN, .BUSY, .DATA_VALID, .RESULT,
        .POLARITY, .OVERRANGE, .DB_OUT, .DB_OE, .SW_ZERO_LOOP, .SW_COMMON_SHORT,
        .SW_INPUT_CONNECT, .SW_NEG_TO_COMMON, .SW_PRIMARY_REF_CAP, .SW_FINE_REF_CAP
    );
    msa_host_model host_u (
        .clk(REF_CLK), .busy(BUSY), .db(DB_OUT), .db_oe(DB_OE), .ce_n(CHIP_ENABLE_N),
        .cs(CHIP_SELECT), .cvt_n(CONVERT_N), .rd_n(READ_N), .lo_sel(LOW_HIGH_SEL),
        .ovr_sel(OVR_POL_SEL)
    );

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic step();
        @(posedge REF_CLK);
        #1;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_in(input logic [15:0] got, input int lo, input int hi);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wait_busy(input logic lvl, input int max, output int n);
        n = 0;
        while (BUSY !== lvl && n < max) begin
            step();
            n++;
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset_state();
        check({8'h00, BUSY, DATA_VALID, SW_ZERO_LOOP, SW_COMMON_SHORT, SW_INPUT_CONNECT,
               SW_NEG_TO_COMMON, SW_PRIMARY_REF_CAP, SW_FINE_REF_CAP}, 16'h0034);
        check({1'b0, RESULT}, 16'h0000);
    endtask

    task automatic t_overrange();
        int n;
        logic [7:0] b;
        logic oe;
        COMP_IN = 1'b0;
        host_u.start(1'b1);
        wait_busy(1'b1, 3000, n);
        check_in(16'(n), 2004, 2018);
        wait_busy(1'b0, 4000, n);
        check(16'(n), 16'h0D10);
        check({13'h0000, DATA_VALID, OVERRANGE, POLARITY}, 16'h0006);
        check({8'h00, RESULT[7:0]}, 16'h00BF);
        host_u.read_byte(1'b1, 1'b0, 1'b1, b, oe);
        check({7'h00, oe, b}, 16'h0180);
        host_u.read_byte(1'b1, 1'b0, 1'b0, b, oe);
        check({7'h00, oe, b}, 16'h0100);
        host_u.read_byte(1'b1, 1'b1, 1'b0, b, oe);
        check({7'h00, oe, b}, 16'h01BF);
    endtask

    task automatic t_hold();
        int n;
        logic [7:0] b;
        logic oe;
        host_u.start(1'b0);
        wait_busy(1'b1, 2100, n);
        check(16'(n), 16'h0834);
        check({14'h0000, DATA_VALID, OVERRANGE}, 16'h0003);
        check({1'b0, RESULT}, 16'h00BF);
        host_u.read_byte(1'b0, 1'b1, 1'b0, b, oe);
        check({15'h0000, oe}, 16'h0000);
    endtask

    task automatic t_crossing();
        int n;
        COMP_IN = 1'b1;
        host_u.start(1'b1);
        check({15'h0000, DATA_VALID}, 16'h0000);
        wait_busy(1'b1, 3000, n);
        repeat (100) step();
        COMP_IN = 1'b0;
        n = 0;
        while (SW_FINE_REF_CAP !== 1'b1 && n < 3000) begin
            step();
            n++;
        end
        check_in(16'(n), 1, 12);
        repeat (160) step();
        COMP_IN = 1'b1;
        wait_busy(1'b0, 4000, n);
        check({13'h0000, DATA_VALID, OVERRANGE, POLARITY}, 16'h0005);
        check_in({7'h00, RESULT[14:6]}, 22, 27);
        check_in({10'h000, RESULT[5:0]}, 37, 42);
    endtask

    task automatic t_continuous();
        int n;
        MODE_SELECT_INPUT = 1'b1;
        wait_busy(1'b1, 3000, n);
        wait_busy(1'b0, 4000, n);
        wait_busy(1'b1, 3000, n);
        // fall to next rise is the cycle minus the busy time
        check(16'(n), 16'h06F0);
        repeat (200) step();
        NRST = 1'b0;
        MODE_SELECT_INPUT = 1'b0;
        repeat (10) step();
        t_reset_state();
        NRST = 1'b1;
        wait_busy(1'b1, 2100, n);
        check(16'(n), 16'h0834);
    endtask

    initial begin
        repeat (8) step();
        t_reset_state();
        repeat (2) step();
        NRST = 1'b1;
        t_overrange();
        t_hold();
        t_crossing();
        t_continuous();
        final_report();
    end

    // about 22300 cycles are needed; this leaves ample margin
    initial begin
        #400000;
        bad_count++;
        final_report();
    end
endmodule // msa_sequencer_test
